// file: scrb_map.vh
// Register offsets, field positions and reset values of the SPI config bank
`ifndef SCRB_MAP_VH
`define SCRB_MAP_VH
`define SCRB_ADDR_SETUP_A     15'h0000
`define SCRB_ADDR_SETUP_B     15'h0001
`define SCRB_ADDR_POWER_MODE  15'h0002
`define SCRB_ADDR_CLASS       15'h0003
`define SCRB_ADDR_RSVD_4      15'h0004
`define SCRB_ADDR_RSVD_5      15'h0005
`define SCRB_ADDR_REVISION    15'h0006
`define SCRB_ADDR_MAKER_HI    15'h000c
`define SCRB_ADDR_MAKER_LO    15'h000d
`define SCRB_ADDR_STREAM_CTL  15'h0010
`define SCRB_ADDR_MAX         15'h7fff
`define SCRB_ADDR_MIN         15'h0000
`define SCRB_BIT_SOFT_RESET   7
`define SCRB_BIT_ADDR_DIR     5
`define SCRB_BIT_ADDR_HOLD    0
`define SCRB_ADDR_DIR_RST     1'b1
`define SCRB_SETUP_A_FIXED    8'h18
`define SCRB_POWER_MODE_RST   2'h0
`define SCRB_ADDR_HOLD_RST    1'b0
`define SCRB_CLASS_CODE       4'h3
`define SCRB_POWER_DOWN_BIT   1
`define SCRB_REVISION_CODE    8'h5a
`define SCRB_MAKER_CODE       16'h1234
`endif

// file: scrb_addr_step.v
// Streaming address stepper for the SPI config bank
`timescale 1ns/1ps
`default_nettype none
`include "scrb_map.vh"
module scrb_addr_step
(
   input  wire [14:0] addrIn,
   input  wire        ascend,
   input  wire        hold,
   output reg  [14:0] addrOut
);
   // ----------------------------------------
   // Next address
   // ----------------------------------------
   always @*
   begin
      if (hold)
         addrOut = addrIn;
      else if (ascend)
         addrOut = (addrIn == `SCRB_ADDR_MAX) ? `SCRB_ADDR_MIN
                 : addrIn + 15'h0001;
      else
         addrOut = (addrIn == `SCRB_ADDR_MIN) ? `SCRB_ADDR_MAX
                 : addrIn - 15'h0001;
   end
endmodule
`default_nettype wire

// file: scrb_spi_config_bank.v
// SPI configuration register bank with streaming address control
`timescale 1ns/1ps
`default_nettype none
`include "scrb_map.vh"
module scrb_spi_config_bank
(
   input  wire        clk,
   input  wire        rstn,
   input  wire        xferStart,
   input  wire [14:0] xferAddr,
   input  wire        byteDone,
   input  wire        byteWrite,
   input  wire [7:0]  wrData,
   output reg  [7:0]  rdData,
   output reg  [14:0] curAddr,
   output reg         powerDown,
   output reg         addrDirAscend,
   output reg         addrHold
);
   // ----------------------------------------
   // State
   // ----------------------------------------
   reg  [1:0]  powerMode_r;
   reg  [1:0]  powerMode_nxt;
   reg         addrDir_nxt;
   reg         addrHold_nxt;
   reg         softReset_r;
   reg  [14:0] addr_nxt;
   wire [14:0] steppedAddr;
   wire [14:0] selAddr;
   wire        mirrored;
   wire        wrSetupA;
   wire        srtRequest;

   // Bit-reversal check of a whole byte
   function mirrorOk;
      input [7:0] d;
      begin
         mirrorOk = (d[0] == d[7]) && (d[1] == d[6]) &&
                    (d[2] == d[5]) && (d[3] == d[4]);
      end
   endfunction

   // True when a committed write byte targets the given address
   function wrHit;
      input [14:0] a;
      input [14:0] target;
      input        done;
      input        write;
      begin
         wrHit = done && write && (a == target);
      end
   endfunction

   // Register read mux; also used for next-byte prefetch
   function [7:0] readByte;
      input [14:0] a;
      input        dir;
      input [1:0]  mode;
      input        hold;
      reg   [15:0] mk;
      begin
         mk = `SCRB_MAKER_CODE;
         case (a)
            `SCRB_ADDR_SETUP_A:
               readByte = `SCRB_SETUP_A_FIXED |
                  ({7'h00, dir} << `SCRB_BIT_ADDR_DIR) |
                  ({7'h00, dir} << (7 - `SCRB_BIT_ADDR_DIR));
            `SCRB_ADDR_POWER_MODE: readByte = {6'h00, mode};
            `SCRB_ADDR_CLASS:      readByte = {4'h0, `SCRB_CLASS_CODE};
            `SCRB_ADDR_REVISION:   readByte = `SCRB_REVISION_CODE;
            `SCRB_ADDR_MAKER_HI:   readByte = mk[15:8];
            `SCRB_ADDR_MAKER_LO:   readByte = mk[7:0];
            `SCRB_ADDR_STREAM_CTL: readByte = {7'h00, hold};
            default:               readByte = 8'h00;
         endcase
      end
   endfunction

   assign selAddr  = xferStart ? xferAddr : curAddr;
   assign mirrored = mirrorOk(wrData);
   assign wrSetupA = wrHit(curAddr, `SCRB_ADDR_SETUP_A, byteDone, byteWrite);
   // Writes are refused while the soft-reset pulse is live
   assign srtRequest = wrSetupA && mirrored && !softReset_r &&
                       wrData[`SCRB_BIT_SOFT_RESET];

   scrb_addr_step u_step
   (
      .addrIn  (curAddr),
      .ascend  (addrDirAscend),
      .hold    (addrHold),
      .addrOut (steppedAddr)
   );

   // ----------------------------------------
   // Next-state logic
   // ----------------------------------------
   always @*
   begin
      powerMode_nxt = powerMode_r;
      addrDir_nxt   = addrDirAscend;
      addrHold_nxt  = addrHold;
      addr_nxt      = selAddr;
      if (softReset_r)
      begin
         // Direction deliberately kept
         powerMode_nxt = `SCRB_POWER_MODE_RST;
         addrHold_nxt  = `SCRB_ADDR_HOLD_RST;
      end
      else if (byteDone && byteWrite)
      begin
         case (curAddr)
            `SCRB_ADDR_SETUP_A:
               if (mirrored)
                  addrDir_nxt = wrData[`SCRB_BIT_ADDR_DIR];
            `SCRB_ADDR_POWER_MODE:
               powerMode_nxt = wrData[1:0];
            `SCRB_ADDR_STREAM_CTL:
               addrHold_nxt = wrData[`SCRB_BIT_ADDR_HOLD];
            default:
               addrHold_nxt = addrHold;
         endcase
      end
      if (byteDone && !xferStart)
         addr_nxt = steppedAddr;
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   // Power mode field and its registered power-down flag
   always @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         powerMode_r <= `SCRB_POWER_MODE_RST;
         powerDown   <= 1'b0;
      end
      else
      begin
         powerMode_r <= powerMode_nxt;
         // Modes 0/1 run, 2/3 power down
         powerDown   <= powerMode_nxt[`SCRB_POWER_DOWN_BIT];
      end
   end

   // Direction follows rstn only, never the soft reset
   always @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         addrDirAscend <= `SCRB_ADDR_DIR_RST;
      end
      else
      begin
         addrDirAscend <= addrDir_nxt;
      end
   end

   always @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         addrHold <= `SCRB_ADDR_HOLD_RST;
      end
      else
      begin
         addrHold <= addrHold_nxt;
      end
   end

   // Pulse one cycle; the bit never reads back set
   always @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         softReset_r <= 1'b0;
      end
      else
      begin
         softReset_r <= srtRequest;
      end
   end

   always @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         curAddr <= 15'h0000;
      end
      else
      begin
         curAddr <= addr_nxt;
      end
   end

   // Fetched ahead so the byte stands with its new address
   always @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         rdData <= 8'h00;
      end
      else
      begin
         rdData <= readByte(addr_nxt, addrDir_nxt, powerMode_nxt,
                            addrHold_nxt);
      end
   end
endmodule
`default_nettype wire

// file: scrb_checker.sv
// Port assertions for the SPI config bank
`timescale 1ns/1ps
`default_nettype none
`include "scrb_map.vh"
module scrb_checker
(
   input wire clk, rstn, xferStart, byteDone, byteWrite,
   input wire [14:0] xferAddr, curAddr,
   input wire [7:0] wrData, rdData,
   input wire powerDown, addrDirAscend, addrHold
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   // Writes to 0x0 and 0x10 retune only later steps, never their own
   wire stp = byteDone && !xferStart && curAddr != 15'h0 && curAddr != 15'h10;
   wire [15:0] mk = `SCRB_MAKER_CODE;
   reg lastW;
   always @(posedge clk)
      if (byteDone)
         lastW <= wrData[1];
   a_start_load: assert property (xferStart |=> curAddr == $past(xferAddr))
      else $error("start address not loaded");
   a_step_up: assert property (stp && !addrHold && addrDirAscend |=>
      curAddr == $past(curAddr) + 15'h1) else $error("no ascend step");
   a_step_down: assert property (stp && !addrHold && !addrDirAscend |=>
      curAddr == $past(curAddr) - 15'h1) else $error("no descend step");
   a_hold_addr: assert property (stp && addrHold |=> $stable(curAddr))
      else $error("held address moved");
   a_idle_addr: assert property (!xferStart && !byteDone |=> $stable(curAddr))
      else $error("address moved without a byte");
   a_class_read: assert property (curAddr == 15'h3 && $past(xferStart || byteDone)
      |-> rdData == {4'h0, `SCRB_CLASS_CODE}) else $error("class code wrong");
   a_maker_read: assert property (curAddr[14:1] == 14'h6 && $past(byteDone)
      |-> rdData == (curAddr[0] ? mk[7:0] : mk[15:8])) else $error("maker wrong");
   a_dir_kept: assert property (!$past(byteDone && curAddr == 15'h0)
      |-> $stable(addrDirAscend)) else $error("direction changed");
   a_mode_power: assert property (byteDone && byteWrite && !xferStart &&
      curAddr == 15'h2 |-> ##[1:2] powerDown == lastW) else $error("power mode");
endmodule
bind scrb_spi_config_bank scrb_checker chk (.*);
`default_nettype wire

// file: scrb_host.sv
// Host model driving frame starts and bytes
`timescale 1ns/1ps
`default_nettype none
module scrb_host
(
   input wire clk,
   output logic xferStart, byteDone, byteWrite,
   output logic [14:0] xferAddr,
   output logic [7:0] wrData
);
   initial
   begin
      xferStart <= 1'b0;
      byteDone <= 1'b0;
      byteWrite <= 1'b0;
      xferAddr <= 15'h0;
      wrData <= 8'h0;
   end
   // Released lines show the inverse so stale data never passes
   task start(input [14:0] a);
   begin
      @(posedge clk);
      xferStart <= 1'b1;
      xferAddr <= a;
      @(posedge clk);
      xferStart <= 1'b0;
      xferAddr <= ~a;
   end
   endtask
   task put(input w, input [7:0] d);
   begin
      @(posedge clk);
      byteDone <= 1'b1;
      byteWrite <= w;
      wrData <= d;
      @(posedge clk);
      byteDone <= 1'b0;
      wrData <= ~d;
   end
   endtask
endmodule
`default_nettype wire

// file: scrb_spi_config_bank_tb.sv
// Self-checking testbench for the SPI config bank
`timescale 1ns/1ps
`default_nettype none
module scrb_spi_config_bank_tb;
   logic clk = 1'b0, rstn = 1'b0;
   wire xs, bd, bw, pd, ad, ah;
   wire [14:0] xa, ca;
   wire [7:0] wd, rd;
   int fails = 0, compares = 0, cyc = 0, i;
   logic [7:0] map [0:6] = '{8'h3c, 8'h0, 8'h0, 8'h03, 8'h0, 8'h0, 8'h5a};
   scrb_host host (.clk(clk), .xferStart(xs), .xferAddr(xa), .byteDone(bd),
      .byteWrite(bw), .wrData(wd));
   scrb_spi_config_bank dut (.clk(clk), .rstn(rstn), .xferStart(xs),
      .xferAddr(xa), .byteDone(bd), .byteWrite(bw), .wrData(wd), .rdData(rd),
      .curAddr(ca), .powerDown(pd), .addrDirAscend(ad), .addrHold(ah));
   initial forever #20 clk = ~clk;
   task chk(input [15:0] s, e);
   begin
      compares++;
      if (s !== e)
      begin
         fails++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
      end
   end
   endtask
   task test_done;
   begin
      $display("compares=%0d fails=%0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   end
   endtask
   // Extra edge is margin only; the power flag registers on the write edge
   task wr(input [14:0] a, input [7:0] d);
   begin
      host.start(a);
      host.put(1'b1, d);
      @(posedge clk);
      #1;
   end
   endtask
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 2000)
      begin
         fails++;
         test_done;
      end
   end
   initial
   begin
      repeat (12) @(posedge clk);
      rstn <= 1'b1;
      host.start(15'h0);
      for (i = 0; i < 7; i++)
      begin
         #1 chk(ca, i);
         chk(rd, map[i]);
         host.put(1'b0, 8'h0);
      end
      host.start(15'hc);
      #1 chk(rd, 8'h12);
      host.put(1'b0, 8'h0);
      #1 chk(rd, 8'h34);
      wr(15'h1, 8'hff);
      host.start(15'h1);
      #1 chk(rd, 8'h0);
      $display("test map done");
      for (i = 0; i < 4; i++)
      begin
         wr(15'h2, i[7:0]);
         chk(pd, i[1]);
      end
      wr(15'h10, 8'h01);
      chk(ah, 1);
      host.start(15'h10);
      host.put(1'b0, 8'h0);
      #1 chk(ca, 15'h10);
      chk(rd, 8'h01);
      wr(15'h0, 8'h18);
      chk(ad, 0);
      wr(15'h0, 8'h20);
      chk(ad, 0);
      wr(15'h10, 8'h0);
      chk(ah, 0);
      host.start(15'h0);
      host.put(1'b0, 8'h0);
      #1 chk(ca, 15'h7fff);
      $display("test stream done");
      wr(15'h2, 8'h02);
      wr(15'h10, 8'h01);
      wr(15'h0, 8'h81);
      repeat (3) @(posedge clk);
      #1 chk({ah, pd}, 0);
      host.start(15'h0);
      #1 chk(rd, 8'h18);
      wr(15'h0, 8'h3c);
      host.start(15'h7fff);
      host.put(1'b0, 8'h0);
      #1 chk(ca, 15'h0);
      $display("test soft reset done");
      test_done;
   end
endmodule
`default_nettype wire
